// >>> core/hb_spi_ctrl.sv
// Top of the half-bridge serial control and fault report block.
`timescale 1ns/1ps
module hb_spi_ctrl #(
	parameter int OC_LONG_CYC = hb_spi_pkg::OC_LONG_CYC,
	parameter int OC_SHORT_CYC = hb_spi_pkg::OC_SHORT_CYC,
	parameter int UL_DELAY_CYC = hb_spi_pkg::UL_DELAY_CYC
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic SCLK,
	input wire logic FRAME_SELECT_N,
	input wire logic SI,
	output logic SO,
	output logic SO_OE_N,
	input wire logic LOGIC_UNDERVOLT,
	input wire logic SUPPLY_UNDERVOLT,
	input wire logic SUPPLY_OVERVOLT,
	input wire logic THERMAL_WARN,
	input wire logic [hb_spi_pkg::LEGS-1:0] OVERCURRENT,
	input wire logic [hb_spi_pkg::LEGS-1:0] UNDERLOAD,
	output logic [hb_spi_pkg::LEGS-1:0] DRV_ON
);
	localparam logic [hb_spi_pkg::TMR_W-1:0] OC_LONG_LIM = hb_spi_pkg::TMR_W'(OC_LONG_CYC - 1);
	localparam logic [hb_spi_pkg::TMR_W-1:0] OC_SHORT_LIM = hb_spi_pkg::TMR_W'(OC_SHORT_CYC - 1);
	localparam logic [hb_spi_pkg::TMR_W-1:0] UL_LIM = hb_spi_pkg::TMR_W'(UL_DELAY_CYC - 1);
	localparam logic [hb_spi_pkg::FILT_W-1:0] FILT_LOAD =
		hb_spi_pkg::FILT_W'(hb_spi_pkg::FILTER_CYC);

	logic [hb_spi_pkg::SYNC_W-1:0] sync_in;
	logic [hb_spi_pkg::SYNC_W-1:0] sync_s;
	logic [hb_spi_pkg::WORD_BITS-1:0] rx_word;
	logic [hb_spi_pkg::CNT_W-1:0] bit_cnt;
	logic link_first;
	logic link_sr0;

	logic csb_s;
	logic luv_s;
	logic suv_s;
	logic sov_s;
	logic tw_s;
	logic first_s;
	logic sr0_s;
	logic [hb_spi_pkg::LEGS-1:0] oc_s;
	logic [hb_spi_pkg::LEGS-1:0] ul_s;

	hb_spi_pkg::frame_state_type fr_q;
	logic saw_clk_q;
	logic accept;
	logic clr;

	logic [hb_spi_pkg::LEGS-1:0] cmd_legs_q;
	logic ov_en_q;
	logic ul_en_q;
	logic oc_sel_q;

	logic [hb_spi_pkg::PAIRS-1:0] pair_blk_q;
	logic [hb_spi_pkg::PAIRS-1:0] pair_both;
	logic [hb_spi_pkg::LEGS-1:0] oc_lat_q;
	logic [hb_spi_pkg::LEGS-1:0] oc_hit;
	logic [hb_spi_pkg::LEGS-1:0] ul_lat_q;
	logic [hb_spi_pkg::TMR_W-1:0] ul_tmr_q;
	logic ul_hit;
	logic [hb_spi_pkg::FILT_W-1:0] filt_q;
	logic filt_busy;

	logic therm_q;
	logic shoot_q;
	logic oc_flag_q;
	logic ul_flag_q;
	logic psf_q;

	logic [hb_spi_pkg::LEGS-1:0] drv_q;
	logic [hb_spi_pkg::LEGS-1:0] drv_d;
	logic [hb_spi_pkg::WORD_BITS-1:0] status;
	logic [hb_spi_pkg::WORD_BITS-1:0] snap_q;
	logic so_q;
	logic so_oe_n_q;

	// Every status pin, the select pin and both link flags go through two flops before the core looks at them.
	always_comb begin
		sync_in = '0;
		sync_in[hb_spi_pkg::SY_CSB] = FRAME_SELECT_N;
		sync_in[hb_spi_pkg::SY_LUV] = LOGIC_UNDERVOLT;
		sync_in[hb_spi_pkg::SY_SUV] = SUPPLY_UNDERVOLT;
		sync_in[hb_spi_pkg::SY_SOV] = SUPPLY_OVERVOLT;
		sync_in[hb_spi_pkg::SY_TW] = THERMAL_WARN;
		sync_in[hb_spi_pkg::SY_FIRST] = link_first;
		sync_in[hb_spi_pkg::SY_SR0] = link_sr0;
		sync_in[hb_spi_pkg::SY_OC +: hb_spi_pkg::LEGS] = OVERCURRENT;
		sync_in[hb_spi_pkg::SY_UL +: hb_spi_pkg::LEGS] = UNDERLOAD;
	end

	hb_sync #(
		.W(hb_spi_pkg::SYNC_W),
		.RST_VAL(hb_spi_pkg::SYNC_RST)
	) u_sync (
		.clk(MCLK),
		.rst_n(RSTN),
		.async_in(sync_in),
		.sync_out(sync_s)
	);

	assign csb_s = sync_s[hb_spi_pkg::SY_CSB];
	assign luv_s = sync_s[hb_spi_pkg::SY_LUV];
	assign suv_s = sync_s[hb_spi_pkg::SY_SUV];
	assign sov_s = sync_s[hb_spi_pkg::SY_SOV];
	assign tw_s = sync_s[hb_spi_pkg::SY_TW];
	assign first_s = sync_s[hb_spi_pkg::SY_FIRST];
	assign sr0_s = sync_s[hb_spi_pkg::SY_SR0];
	assign oc_s = sync_s[hb_spi_pkg::SY_OC +: hb_spi_pkg::LEGS];
	assign ul_s = sync_s[hb_spi_pkg::SY_UL +: hb_spi_pkg::LEGS];

	// The snapshot is frozen for the whole frame, so the link may read it without a crossing.
	hb_link u_link (
		.sclk(SCLK),
		.frame_select_n(FRAME_SELECT_N),
		.si(SI),
		.snap(snap_q),
		.rx_word(rx_word),
		.bit_cnt(bit_cnt),
		.first(link_first),
		.sr0(link_sr0)
	);

	// Frame tracking. The received word and count are still because the serial clock
	// stays low once select has risen, so they are read directly in the latch state.
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			fr_q <= hb_spi_pkg::FR_IDLE;
			saw_clk_q <= 1'b0;
		end else begin
			case (fr_q)
				hb_spi_pkg::FR_IDLE: begin
					saw_clk_q <= 1'b0;
					if (!csb_s) begin
						fr_q <= hb_spi_pkg::FR_SHIFT;
					end
				end
				hb_spi_pkg::FR_SHIFT: begin
					if (!first_s) begin
						saw_clk_q <= 1'b1;
					end
					if (csb_s) begin
						fr_q <= hb_spi_pkg::FR_LATCH;
					end
				end
				hb_spi_pkg::FR_LATCH: begin
					fr_q <= hb_spi_pkg::FR_IDLE;
				end
				default: begin
					fr_q <= hb_spi_pkg::FR_IDLE;
				end
			endcase
		end
	end

	// A frame with no clocks or a count off a multiple of 16 is dropped whole.
	assign accept = (fr_q == hb_spi_pkg::FR_LATCH) && saw_clk_q && (bit_cnt == hb_spi_pkg::CNT_ZERO)
		&& !luv_s;
	assign clr = accept && rx_word[hb_spi_pkg::BIT_CLR];

	// Settings register. Bits 7 to 12 of the word are not stored.
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cmd_legs_q <= hb_spi_pkg::LEGS_RST;
			ov_en_q <= 1'b0;
			ul_en_q <= 1'b0;
			oc_sel_q <= 1'b0;
		end else if (accept) begin
			cmd_legs_q <= rx_word[hb_spi_pkg::BIT_LEG0 +: hb_spi_pkg::LEGS];
			ov_en_q <= rx_word[hb_spi_pkg::BIT_OV_EN];
			ul_en_q <= rx_word[hb_spi_pkg::BIT_UL_EN];
			oc_sel_q <= rx_word[hb_spi_pkg::BIT_OC_SEL];
		end
	end

	// Shoot-through guard, one lane per half-bridge pair.
	for (genvar p = 0; p < hb_spi_pkg::PAIRS; p++) begin : g_pair
		assign pair_both[p] = rx_word[hb_spi_pkg::BIT_LEG0 + 2 * p]
			&& rx_word[hb_spi_pkg::BIT_LEG0 + 2 * p + 1];
		always_ff @(posedge MCLK or negedge RSTN) begin
			if (!RSTN) begin
				pair_blk_q[p] <= 1'b0;
			end else if (accept && pair_both[p]) begin
				pair_blk_q[p] <= 1'b1;
			end else if (clr) begin
				pair_blk_q[p] <= 1'b0;
			end
		end
	end

	// Overcurrent timers. The delay is caught when a timer starts and is not
	// changed by a later command until the condition ends.
	for (genvar i = 0; i < hb_spi_pkg::LEGS; i++) begin : g_oc
		logic [hb_spi_pkg::TMR_W-1:0] tmr_q;
		logic [hb_spi_pkg::TMR_W-1:0] lim_q;
		logic run;

		assign run = drv_q[i] && oc_s[i];
		assign oc_hit[i] = run && (tmr_q == lim_q);

		always_ff @(posedge MCLK or negedge RSTN) begin
			if (!RSTN) begin
				tmr_q <= hb_spi_pkg::TMR_ZERO;
				lim_q <= OC_LONG_LIM;
			end else if (!run) begin
				tmr_q <= hb_spi_pkg::TMR_ZERO;
				lim_q <= oc_sel_q ? OC_SHORT_LIM : OC_LONG_LIM;
			end else if (tmr_q != lim_q) begin
				tmr_q <= tmr_q + hb_spi_pkg::TMR_ONE;
			end
		end

		always_ff @(posedge MCLK or negedge RSTN) begin
			if (!RSTN) begin
				oc_lat_q[i] <= 1'b0;
			end else if (oc_hit[i]) begin
				oc_lat_q[i] <= 1'b1;
			end else if (clr) begin
				oc_lat_q[i] <= 1'b0;
			end
		end
	end

	// One underload timer serves every leg, so a second leg inherits what is left of it.
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ul_tmr_q <= hb_spi_pkg::TMR_ZERO;
		end else if (!(|(ul_s & drv_q))) begin
			ul_tmr_q <= hb_spi_pkg::TMR_ZERO;
		end else if (ul_tmr_q != UL_LIM) begin
			ul_tmr_q <= ul_tmr_q + hb_spi_pkg::TMR_ONE;
		end
	end

	assign ul_hit = (|(ul_s & drv_q)) && (ul_tmr_q == UL_LIM);

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ul_lat_q <= hb_spi_pkg::LEGS_RST;
		end else begin
			ul_lat_q <= (clr ? hb_spi_pkg::LEGS_RST : ul_lat_q)
				| ((ul_hit && ul_en_q) ? (ul_s & drv_q) : hb_spi_pkg::LEGS_RST);
		end
	end

	// After a clear, level faults wait out the filter time before they latch again.
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			filt_q <= hb_spi_pkg::FILT_ZERO;
		end else if (clr) begin
			filt_q <= FILT_LOAD;
		end else if (filt_q != hb_spi_pkg::FILT_ZERO) begin
			filt_q <= filt_q - hb_spi_pkg::FILT_ONE;
		end
	end

	assign filt_busy = (filt_q != hb_spi_pkg::FILT_ZERO);

	// Fault flags. A set arriving in the clearing cycle wins.
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			therm_q <= 1'b0;
			shoot_q <= 1'b0;
			oc_flag_q <= 1'b0;
			ul_flag_q <= 1'b0;
			psf_q <= 1'b0;
		end else begin
			therm_q <= (therm_q && !clr) || (tw_s && !filt_busy);
			shoot_q <= (shoot_q && !clr) || (accept && (|pair_both));
			oc_flag_q <= (oc_flag_q && !clr) || (|oc_hit);
			ul_flag_q <= (ul_flag_q && !clr) || ul_hit;
			psf_q <= (psf_q && !clr) || ((sov_s || suv_s) && !filt_busy);
		end
	end

	// Settings are kept through lockouts, so drivers come back on their own once a voltage fault ends; latched lockouts need a clear.
	always_comb begin
		drv_d = cmd_legs_q & ~oc_lat_q & ~ul_lat_q;
		for (int p = 0; p < hb_spi_pkg::PAIRS; p++) begin
			if (pair_blk_q[p]) begin
				drv_d[2 * p] = 1'b0;
				drv_d[2 * p + 1] = 1'b0;
			end
		end
		if (suv_s || luv_s) begin
			drv_d = hb_spi_pkg::LEGS_RST;
		end
		if (ov_en_q && sov_s) begin
			drv_d = hb_spi_pkg::LEGS_RST;
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			drv_q <= hb_spi_pkg::LEGS_RST;
		end else begin
			drv_q <= drv_d;
		end
	end

	assign DRV_ON = drv_q;

	// Report word.
	assign status = {psf_q, ul_flag_q, oc_flag_q, shoot_q, hb_spi_pkg::UNUSED_OUT, drv_q,
		therm_q};

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			snap_q <= hb_spi_pkg::WORD_RST;
		end else if (fr_q == hb_spi_pkg::FR_IDLE && csb_s) begin
			snap_q <= status;
		end
	end

	// The output is resampled on this clock; with a 4 ns period it trails the serial
	// clock by at most 12 ns, well inside the output valid time.
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			so_q <= 1'b0;
			so_oe_n_q <= 1'b1;
		end else begin
			so_q <= first_s ? snap_q[0] : sr0_s;
			so_oe_n_q <= csb_s;
		end
	end

	assign SO = so_q;
	assign SO_OE_N = so_oe_n_q;
endmodule : hb_spi_ctrl

// >>> core/hb_spi_pkg.sv
// Shared constants for the half-bridge serial control block.
package hb_spi_pkg;
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 4;
	localparam int LEGS = 6;
	localparam int PAIRS = 3;
	localparam int TMR_W = 17;

	// Command word field positions.
	localparam int BIT_CLR = 0;
	localparam int BIT_LEG0 = 1;
	localparam int BIT_OC_SEL = 13;
	localparam int BIT_UL_EN = 14;
	localparam int BIT_OV_EN = 15;

	// Report word field positions.
	localparam int BIT_THERM = 0;
	localparam int BIT_SHOOT = 12;
	localparam int BIT_OC = 13;
	localparam int BIT_UL = 14;
	localparam int BIT_PSF = 15;
	localparam logic [4:0] UNUSED_OUT = 5'h00;

	// Reset values.
	localparam logic [LEGS-1:0] LEGS_RST = 6'h00;
	localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [TMR_W-1:0] TMR_ZERO = 17'h00000;
	localparam logic [TMR_W-1:0] TMR_ONE = 17'h00001;

	// Timing, in printed units, and derived cycle counts.
	localparam int MCLK_MHZ = 250;
	localparam int MCLK_PERIOD_NS = 4;
	localparam int OC_LONG_US = 200;
	localparam int OC_SHORT_US = 25;
	localparam int UL_DELAY_US = 350;
	localparam int FILTER_NS = 1000;
	localparam int OC_LONG_CYC = OC_LONG_US * MCLK_MHZ;
	localparam int OC_SHORT_CYC = OC_SHORT_US * MCLK_MHZ;
	localparam int UL_DELAY_CYC = UL_DELAY_US * MCLK_MHZ;
	localparam int FILTER_CYC = (FILTER_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int FILT_W = 9;
	localparam logic [FILT_W-1:0] FILT_ZERO = 9'h000;
	localparam logic [FILT_W-1:0] FILT_ONE = 9'h001;

	// Synchroniser lane map.
	localparam int SYNC_W = 19;
	localparam int SY_CSB = 0;
	localparam int SY_LUV = 1;
	localparam int SY_SUV = 2;
	localparam int SY_SOV = 3;
	localparam int SY_TW = 4;
	localparam int SY_FIRST = 5;
	localparam int SY_SR0 = 6;
	localparam int SY_OC = 7;
	localparam int SY_UL = 13;
	localparam logic [SYNC_W-1:0] SYNC_RST = 19'h00021;

	typedef enum logic [2:0] {
		FR_IDLE = 3'h1,
		FR_SHIFT = 3'h2,
		FR_LATCH = 3'h4
	} frame_state_type;
endpackage : hb_spi_pkg

// >>> core/hb_sync.sv
// Two-flop level synchroniser, one lane per bit.
`timescale 1ns/1ps
module hb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	for (genvar i = 0; i < W; i++) begin : g_lane
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_q[i] <= RST_VAL[i];
				sync_out[i] <= RST_VAL[i];
			end else begin
				meta_q[i] <= async_in[i];
				sync_out[i] <= meta_q[i];
			end
		end
	end
endmodule : hb_sync

// >>> core/hb_link.sv
// Serial shift and bit count logic clocked by the host serial clock.
`timescale 1ns/1ps
module hb_link (
	input wire logic sclk,
	input wire logic frame_select_n,
	input wire logic si,
	input wire logic [hb_spi_pkg::WORD_BITS-1:0] snap,
	output logic [hb_spi_pkg::WORD_BITS-1:0] rx_word,
	output logic [hb_spi_pkg::CNT_W-1:0] bit_cnt,
	output logic first,
	output logic sr0
);
	logic [hb_spi_pkg::WORD_BITS-1:0] sr_q;
	logic [hb_spi_pkg::CNT_W-1:0] cnt_q;
	logic first_q;

	// The select line arms the frame; the serial clock may stand still outside frames.
	always_ff @(posedge sclk or posedge frame_select_n) begin
		if (frame_select_n) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	// Shift register and count keep their value after the frame so the core can read them.
	always_ff @(posedge sclk) begin
		if (first_q) begin
			sr_q <= {si, snap[hb_spi_pkg::WORD_BITS-1:1]};
			cnt_q <= hb_spi_pkg::CNT_ONE;
		end else begin
			sr_q <= {si, sr_q[hb_spi_pkg::WORD_BITS-1:1]};
			cnt_q <= cnt_q + hb_spi_pkg::CNT_ONE;
		end
	end

	assign rx_word = sr_q;
	assign bit_cnt = cnt_q;
	assign first = first_q;
	assign sr0 = sr_q[0];
endmodule : hb_link

// >>> tb/hb_host_model.sv
// Host serial master model that frames and clocks command words and reads back the report word.
`timescale 1ns/1ps
module hb_host_model (
	output logic SCLK,
	output logic FRAME_SELECT_N,
	output logic SI,
	input wire logic SO,
	input wire logic SO_OE_N
);
	// The link has no reset of its own, so a rising select arms it before the first frame.
	initial begin
		SCLK = 1'h0;
		SI = 1'h0;
		FRAME_SELECT_N = 1'h0;
		#1 FRAME_SELECT_N = 1'h1;
	end

	// A released output is read inverted, so a stale level reads back as the opposite bit and still matches when that bit is expected.
	task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] got);
		got = 32'h00000000;
		#2.3 FRAME_SELECT_N = 1'h0;
		#100;
		for (int i = 0; i < n; i++) begin
			SI = d[i];
			#6 SCLK = 1'h1;
			#4 got[i] = SO_OE_N ? ~SO : SO;
			#2 SCLK = 1'h0;
		end
		SI = 1'h0;
		#100 FRAME_SELECT_N = 1'h1;
		#5000;
	endtask : xfer
endmodule : hb_host_model

// >>> tb/hb_spi_ctrl_properties.sv
// Port checks for the half-bridge serial control block, bound to its top.
`timescale 1ns/1ps
module hb_spi_ctrl_properties #(
	parameter int OC_LONG_CYC = hb_spi_pkg::OC_LONG_CYC
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic FRAME_SELECT_N,
	input wire logic SO_OE_N,
	input wire logic LOGIC_UNDERVOLT,
	input wire logic SUPPLY_UNDERVOLT,
	input wire logic SUPPLY_OVERVOLT,
	input wire logic [hb_spi_pkg::LEGS-1:0] OVERCURRENT,
	input wire logic [hb_spi_pkg::LEGS-1:0] UNDERLOAD,
	input wire logic [hb_spi_pkg::LEGS-1:0] DRV_ON
);
	// Cycles leg 0 stays on under overcurrent; the slack of 8 covers the synchroniser.
	int oc_run_q;
	logic quiet;
	assign quiet = !FRAME_SELECT_N && OVERCURRENT == 6'h00 && UNDERLOAD == 6'h00
		&& !SUPPLY_OVERVOLT && !SUPPLY_UNDERVOLT && !LOGIC_UNDERVOLT;
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			oc_run_q <= 0;
		end else if (OVERCURRENT[0] && DRV_ON[0]) begin
			oc_run_q <= oc_run_q + 1;
		end else begin
			oc_run_q <= 0;
		end
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);

	a_oe_idle_high: assert property (FRAME_SELECT_N [*5] |-> SO_OE_N)
		else $error("serial output driven with frame select high");
	a_oe_release_cause: assert property (
		$rose(SO_OE_N) |-> $past(FRAME_SELECT_N, 2) || $past(LOGIC_UNDERVOLT, 2))
		else $error("serial output released inside a frame");
	a_oe_fall_bound: assert property (
		$fell(FRAME_SELECT_N) && !LOGIC_UNDERVOLT |-> ##[1:4] !SO_OE_N)
		else $error("serial output not enabled after frame start");
	a_uv_drivers_off: assert property (
		(SUPPLY_UNDERVOLT || LOGIC_UNDERVOLT) [*4] |-> DRV_ON == 6'h00)
		else $error("leg on during undervoltage");
	a_pair_never_both: assert property (
		!(DRV_ON[0] && DRV_ON[1]) && !(DRV_ON[2] && DRV_ON[3]) && !(DRV_ON[4] && DRV_ON[5]))
		else $error("both legs of a pair on");
	a_drv_quiet_frame: assert property (quiet [*6] |-> $stable(DRV_ON))
		else $error("legs changed inside a frame");
	a_drv_on_cause: assert property (
		|(DRV_ON & ~$past(DRV_ON)) |-> FRAME_SELECT_N || $past(SUPPLY_OVERVOLT, 4)
		|| $past(SUPPLY_UNDERVOLT, 4) || $past(LOGIC_UNDERVOLT, 4))
		else $error("leg turned on without cause");
	a_oc_bound: assert property (oc_run_q < OC_LONG_CYC + 8)
		else $error("leg kept on past the overcurrent delay");
endmodule : hb_spi_ctrl_properties

bind hb_spi_ctrl hb_spi_ctrl_properties #(.OC_LONG_CYC(OC_LONG_CYC))
	u_hb_spi_ctrl_properties (
	.MCLK(MCLK),
	.RSTN(RSTN),
	.FRAME_SELECT_N(FRAME_SELECT_N),
	.SO_OE_N(SO_OE_N),
	.LOGIC_UNDERVOLT(LOGIC_UNDERVOLT),
	.SUPPLY_UNDERVOLT(SUPPLY_UNDERVOLT),
	.SUPPLY_OVERVOLT(SUPPLY_OVERVOLT),
	.OVERCURRENT(OVERCURRENT),
	.UNDERLOAD(UNDERLOAD),
	.DRV_ON(DRV_ON)
);

// >>> tb/test_hb_spi_ctrl.sv
// Self-checking bench for the half-bridge serial control block.
`timescale 1ns/1ps
module test_hb_spi_ctrl;
	typedef struct {
		logic [31:0] d;
		int n;
		logic [5:0] drv;
		logic [31:0] rep;
	} row_type;
	// Command bits, clock count, legs expected after it, word read back during it.
	row_type rows [10] = '{
		'{32'h00000002, 16, 6'h01, 32'h00000000},
		'{32'h00001FC8, 16, 6'h24, 32'h00000002},
		'{32'h0000000A, 15, 6'h24, 32'h00000048},
		'{32'h0001000A, 17, 6'h24, 32'h00000048},
		'{32'h0012FFFF, 32, 6'h09, 32'hFFFF0048},
		'{32'h00000002, 0, 6'h09, 32'h00000000},
		'{32'h00000006, 16, 6'h00, 32'h00000012},
		'{32'h00000004, 16, 6'h00, 32'h00001000},
		'{32'h00000005, 16, 6'h02, 32'h00001000},
		'{32'h00000000, 16, 6'h00, 32'h00000004}
	};
	logic MCLK = 1'h0;
	logic RSTN = 1'h0;
	logic SCLK, FRAME_SELECT_N, SI, SO, SO_OE_N;
	logic LOGIC_UNDERVOLT = 1'h0;
	logic SUPPLY_UNDERVOLT = 1'h0;
	logic SUPPLY_OVERVOLT = 1'h0;
	logic THERMAL_WARN = 1'h0;
	logic [5:0] OVERCURRENT = 6'h00;
	logic [5:0] UNDERLOAD = 6'h00;
	logic [5:0] DRV_ON;
	int num_errors = 0;
	int check_count = 0;

	always #2 MCLK = ~MCLK;

	// Long protection counts are shortened so each timeout fits in a few dozen cycles.
	hb_spi_ctrl #(.OC_LONG_CYC(40), .OC_SHORT_CYC(10), .UL_DELAY_CYC(30)) u_hb_spi_ctrl (
		.MCLK(MCLK),
		.RSTN(RSTN),
		.SCLK(SCLK),
		.FRAME_SELECT_N(FRAME_SELECT_N),
		.SI(SI),
		.SO(SO),
		.SO_OE_N(SO_OE_N),
		.LOGIC_UNDERVOLT(LOGIC_UNDERVOLT),
		.SUPPLY_UNDERVOLT(SUPPLY_UNDERVOLT),
		.SUPPLY_OVERVOLT(SUPPLY_OVERVOLT),
		.THERMAL_WARN(THERMAL_WARN),
		.OVERCURRENT(OVERCURRENT),
		.UNDERLOAD(UNDERLOAD),
		.DRV_ON(DRV_ON)
	);

	hb_host_model u_hb_host_model (
		.SCLK(SCLK),
		.FRAME_SELECT_N(FRAME_SELECT_N),
		.SI(SI),
		.SO(SO),
		.SO_OE_N(SO_OE_N)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic waitc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask : waitc

	task automatic fr(input logic [31:0] d, input int n, input logic [31:0] exp);
		logic [31:0] got;
		u_hb_host_model.xfer(d, n, got);
		check("report", got, exp);
	endtask : fr

	task automatic faults(input logic ov, input logic uv, input logic tw,
		input logic [5:0] oc, input logic [5:0] ul, input int n);
		@(posedge MCLK);
		SUPPLY_OVERVOLT <= ov;
		SUPPLY_UNDERVOLT <= uv;
		THERMAL_WARN <= tw;
		OVERCURRENT <= oc;
		UNDERLOAD <= ul;
		waitc(n);
	endtask : faults

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#400000;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(posedge MCLK);
		RSTN <= 1'h1;
		waitc(4);
		check("drv", DRV_ON, 32'h0);
		check("oe", SO_OE_N, 32'h1);
		foreach (rows[i]) begin
			fr(rows[i].d, rows[i].n, rows[i].rep);
			check("drv", DRV_ON, rows[i].drv);
		end
		fr(32'h00008002, 16, 32'h00000000);
		faults(1'h1, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		check("drv", DRV_ON, 32'h0);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		check("drv", DRV_ON, 32'h1);
		fr(32'h00000002, 16, 32'h00008002);
		fr(32'h00000003, 16, 32'h00008002);
		faults(1'h1, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		check("drv", DRV_ON, 32'h1);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		fr(32'h00000002, 16, 32'h00008002);
		fr(32'h00000003, 16, 32'h00008002);
		fr(32'h00000000, 16, 32'h00000002);
		fr(32'h00002003, 16, 32'h00000000);
		faults(1'h0, 1'h0, 1'h0, 6'h01, 6'h00, 25);
		check("drv", DRV_ON, 32'h0);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		check("drv", DRV_ON, 32'h0);
		fr(32'h00000003, 15, 32'h00002000);
		fr(32'h00000003, 16, 32'h00002000);
		faults(1'h0, 1'h0, 1'h0, 6'h01, 6'h00, 25);
		check("drv", DRV_ON, 32'h1);
		waitc(30);
		check("drv", DRV_ON, 32'h0);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		fr(32'h00000001, 16, 32'h00002000);
		fr(32'h00004003, 16, 32'h00000000);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h01, 45);
		check("drv", DRV_ON, 32'h0);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		fr(32'h00000003, 16, 32'h00004000);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h01, 45);
		check("drv", DRV_ON, 32'h1);
		faults(1'h0, 1'h0, 1'h1, 6'h00, 6'h00, 8);
		fr(32'h00000003, 16, 32'h00004003);
		fr(32'h00000003, 16, 32'h00000003);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		fr(32'h00000003, 16, 32'h00000003);
		faults(1'h0, 1'h1, 1'h0, 6'h00, 6'h00, 8);
		check("drv", DRV_ON, 32'h0);
		fr(32'h00000008, 16, 32'h00008000);
		check("drv", DRV_ON, 32'h0);
		faults(1'h0, 1'h0, 1'h0, 6'h00, 6'h00, 8);
		check("drv", DRV_ON, 32'h4);
		@(posedge MCLK);
		LOGIC_UNDERVOLT <= 1'h1;
		waitc(8);
		check("drv", DRV_ON, 32'h0);
		fr(32'h00000010, 16, 32'h00008000);
		@(posedge MCLK);
		LOGIC_UNDERVOLT <= 1'h0;
		waitc(8);
		check("drv", DRV_ON, 32'h4);
		fr(32'h00000010, 16, 32'h00008008);
		check("drv", DRV_ON, 32'h8);
		// A second reset mid-run must drop every leg and wipe the sticky flags.
		@(posedge MCLK);
		RSTN <= 1'h0;
		waitc(6);
		check("drv", DRV_ON, 32'h0);
		check("oe", SO_OE_N, 32'h1);
		@(posedge MCLK);
		RSTN <= 1'h1;
		waitc(3);
		fr(32'h00000002, 16, 32'h00000000);
		check("drv", DRV_ON, 32'h1);
		tally_and_finish();
	end
endmodule : test_hb_spi_ctrl
